// ---- ebac_device.sv ----
// non-volatile byte store with address, data and control registers
//
// Summary of operation
// - 64 bytes, one byte per register access
// - address register 6 bits, upper reads zero
// - control at 0x40, bank 1, indirect only
// - control bits 3..0 permits/launches, upper zero
// - write permit zero blocks every write
// - launch with permit starts write, auto-clear
// - write launch ignored unless permit already set
// - read permit gates read, launch auto-clears
// - read launch ignored unless permit already set
// - software never sets both launches together
// - read order: permit, address, launch, poll
// - read byte held until next operation
// - write order: address, data, permit, launch
// - software masks interrupts around write start
// - write timed by asynchronous internal timer
// - completion shown by launch clear and request
// - done sets write-done and multi-function flags
// - write permit cleared at power-on
// - no low-power entry during a cycle
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module ebac_device #(
  parameter logic [15:0] WRITE_TICKS = ebac_pkg::WR_TICKS
) (
  input  logic      clk,
  input  logic      nrst,
  input  logic      wr_timer_clk,  // free-running write timer clock
  ebac_if.device    bus,
  output logic      cycle_busy
);

  // ----------------------------------------------------------------
  // types and declarations
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EBAC_IDLE  = 3'b001,
    EBAC_READ  = 3'b010,
    EBAC_WRITE = 3'b100
  } ebac_dev_state_t;

  ebac_dev_state_t              state_q;
  logic [ebac_pkg::NVM_AW-1:0]  addr_q;
  logic [7:0]                   data_q;
  logic                         wp_q;
  logic                         wl_q;
  logic                         rp_q;
  logic                         rl_q;
  logic [7:0]                   mem_q [0:ebac_pkg::NVM_DEPTH-1];
  logic [ebac_pkg::NVM_AW-1:0]  cyc_addr_q;
  logic [7:0]                   cyc_data_q;
  logic [1:0]                   rd_cnt_q;
  logic                         start_tgl_q;
  logic                         ts1_q;
  logic                         ts2_q;
  logic                         ts3_q;
  logic                         t_run_q;
  logic [15:0]                  t_cnt_q;
  logic                         done_tgl_q;
  logic                         ds1_q;
  logic                         ds2_q;
  logic                         ds3_q;
  logic                         done_flag_q;
  logic                         mfi_q;
  logic                         wr_addr;
  logic                         wr_data;
  logic                         wr_ctl;
  logic                         rd_ctl;
  logic                         idle;
  logic                         go_wr;
  logic                         go_rd;
  logic                         done_evt;
  logic                         wr_fin;
  logic                         rd_fin;

  // register decode on bank and offset
  function automatic logic hit(input logic       bk,
                               input logic [7:0] a,
                               input logic       want_bk,
                               input logic [7:0] ofs);
    hit = (bk == want_bk) && (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  // direct offsets always reach bank 0, whatever the bank pointer
  assign wr_addr = bus.acc_req & bus.acc_we
                 & (bus.acc_addr == ebac_pkg::ADDR_OFS);
  assign wr_data = bus.acc_req & bus.acc_we
                 & (bus.acc_addr == ebac_pkg::DATA_OFS);
  assign wr_ctl  = bus.acc_req & bus.acc_we
                 & hit(bus.bank_pointer, bus.acc_addr,
                       ebac_pkg::CTL_BANK, ebac_pkg::CTL_OFS);
  assign rd_ctl  = hit(bus.bank_pointer, bus.acc_addr,
                       ebac_pkg::CTL_BANK, ebac_pkg::CTL_OFS);
  assign idle    = (state_q == EBAC_IDLE);
  assign cycle_busy = ~idle;

  // launch accepted only with permit already set and no cycle running
  assign go_wr = wr_ctl & bus.acc_wdata[ebac_pkg::CTL_WL]
               & wp_q & idle;
  // write launch wins if both launches arrive together
  assign go_rd = wr_ctl & bus.acc_wdata[ebac_pkg::CTL_RL]
               & rp_q & idle & ~go_wr;

  assign wr_fin = done_evt & (state_q == EBAC_WRITE);
  assign rd_fin = (state_q == EBAC_READ) && (rd_cnt_q == 2'h1);

  // ----------------------------------------------------------------
  // read data mux
  // ----------------------------------------------------------------
  always_comb
  begin
    bus.acc_rdata = 8'h00;
    if (bus.acc_addr == ebac_pkg::ADDR_OFS)
      bus.acc_rdata = {2'h0, addr_q};
    else if (bus.acc_addr == ebac_pkg::DATA_OFS)
      bus.acc_rdata = data_q;
    else if (rd_ctl)
      bus.acc_rdata = {4'h0, wp_q, wl_q, rp_q, rl_q};
  end

  // ----------------------------------------------------------------
  // address and data registers
  // ----------------------------------------------------------------
  // address register, low six bits only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      addr_q <= ebac_pkg::ADDR_RST;
    else if (wr_addr)
      addr_q <= bus.acc_wdata[ebac_pkg::NVM_AW-1:0];
  end

  // data register, loaded by software or by a finished read
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      data_q <= ebac_pkg::DATA_RST;
    else if (rd_fin)
      data_q <= mem_q[cyc_addr_q];
    else if (wr_data)
      data_q <= bus.acc_wdata;
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  // permits follow software writes, cleared at power-on
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_q <= 1'b0;
      rp_q <= 1'b0;
    end
    else if (wr_ctl)
    begin
      wp_q <= bus.acc_wdata[ebac_pkg::CTL_WP];
      rp_q <= bus.acc_wdata[ebac_pkg::CTL_RP];
    end
  end

  // launch bits: set on accepted launch, cleared by hardware at end
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wl_q <= 1'b0;
      rl_q <= 1'b0;
    end
    else
    begin
      if (wr_fin)
        wl_q <= 1'b0;
      else if (go_wr)
        wl_q <= 1'b1;
      if (rd_fin)
        rl_q <= 1'b0;
      else if (go_rd)
        rl_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------
  // operands latched at launch so later writes cannot disturb them
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q    <= EBAC_IDLE;
      cyc_addr_q <= ebac_pkg::ADDR_RST;
      cyc_data_q <= ebac_pkg::DATA_RST;
      rd_cnt_q   <= 2'h0;
    end
    else
    begin
      case (state_q)
        EBAC_IDLE:
        begin
          if (go_wr || go_rd)
          begin
            cyc_addr_q <= addr_q;
            cyc_data_q <= data_q;
            rd_cnt_q   <= ebac_pkg::RD_CYCLES;
            state_q    <= go_wr ? EBAC_WRITE : EBAC_READ;
          end
        end
        EBAC_READ:
        begin
          rd_cnt_q <= rd_cnt_q - 2'h1;
          if (rd_fin)
            state_q <= EBAC_IDLE;
        end
        EBAC_WRITE:
        begin
          if (wr_fin)
            state_q <= EBAC_IDLE;
        end
        default:
          state_q <= EBAC_IDLE;
      endcase
    end
  end

  // store array, no reset: contents are non-volatile
  always_ff @(posedge clk)
  begin
    if (wr_fin)
      mem_q[cyc_addr_q] <= cyc_data_q;
  end

  // launch toggle handed to the timer domain
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      start_tgl_q <= 1'b0;
    else if (go_wr)
      start_tgl_q <= ~start_tgl_q;
  end

  // ----------------------------------------------------------------
  // write timer domain
  // ----------------------------------------------------------------
  // start toggle synchroniser, ts1 feeds ts2 only
  always_ff @(posedge wr_timer_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ts1_q <= 1'b0;
      ts2_q <= 1'b0;
      ts3_q <= 1'b0;
    end
    else
    begin
      ts1_q <= start_tgl_q;
      ts2_q <= ts1_q;
      ts3_q <= ts2_q;
    end
  end

  // write duration counter, toggles done when it expires
  always_ff @(posedge wr_timer_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      t_run_q    <= 1'b0;
      t_cnt_q    <= 16'h0000;
      done_tgl_q <= 1'b0;
    end
    else if (ts2_q ^ ts3_q)
    begin
      t_run_q <= 1'b1;
      t_cnt_q <= WRITE_TICKS;
    end
    else if (t_run_q)
    begin
      if (t_cnt_q <= 16'h0001)
      begin
        t_run_q    <= 1'b0;
        done_tgl_q <= ~done_tgl_q;
      end
      else
        t_cnt_q <= t_cnt_q - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // completion back in the system domain
  // ----------------------------------------------------------------
  // done toggle synchroniser, ds1 feeds ds2 only
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ds1_q <= 1'b0;
      ds2_q <= 1'b0;
      ds3_q <= 1'b0;
    end
    else
    begin
      ds1_q <= done_tgl_q;
      ds2_q <= ds1_q;
      ds3_q <= ds2_q;
    end
  end

  assign done_evt = ds2_q ^ ds3_q;

  // sticky request flags, a new end beats a clear in the same cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      done_flag_q <= 1'b0;
      mfi_q       <= 1'b0;
    end
    else
    begin
      done_flag_q <= wr_fin | (done_flag_q & ~bus.done_clr);
      mfi_q       <= wr_fin | (mfi_q & ~bus.mfi_clr);
    end
  end

  assign bus.write_done_flag = done_flag_q;
  assign bus.mfi_flag        = mfi_q;

endmodule // ebac_device

// ---- ebac_pkg.sv ----
// shared constants of the byte-wide non-volatile store access block
package ebac_pkg;

  // ----------------------------------------------------------------
  // store geometry
  // ----------------------------------------------------------------
  localparam int          NVM_DEPTH   = 64;
  localparam int          NVM_AW      = 6;

  // ----------------------------------------------------------------
  // device register map (bank, offset)
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_OFS    = 8'h1e; // direct access, bank 0
  localparam logic [7:0]  DATA_OFS    = 8'h1f; // direct access, bank 0
  localparam logic [7:0]  CTL_OFS     = 8'h40; // indirect access only
  localparam logic        CTL_BANK    = 1'h1;
  localparam logic        BANK0       = 1'h0;

  // control register fields
  localparam int          CTL_WP      = 3;     // write permit
  localparam int          CTL_WL      = 2;     // write launch
  localparam int          CTL_RP      = 1;     // read permit
  localparam int          CTL_RL      = 0;     // read launch
  localparam logic [7:0]  CTL_RST     = 8'h00;
  localparam logic [7:0]  CTL_RD_EN   = 8'h02;
  localparam logic [7:0]  CTL_RD_GO   = 8'h03;
  localparam logic [7:0]  CTL_WR_EN   = 8'h08;
  localparam logic [7:0]  CTL_WR_GO   = 8'h0c;
  localparam logic [5:0]  ADDR_RST    = 6'h00;
  localparam logic [7:0]  DATA_RST    = 8'h00;

  // ----------------------------------------------------------------
  // cycle timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  RD_CYCLES   = 2'h2;  // clk cycles per read
  localparam logic [15:0] WR_TICKS    = 16'h0040; // timer ticks per write

  // ----------------------------------------------------------------
  // controller apb register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  APB_CMD     = 8'h00;
  localparam logic [7:0]  APB_ADDR    = 8'h04;
  localparam logic [7:0]  APB_WDATA   = 8'h08;
  localparam logic [7:0]  APB_STATUS  = 8'h0c;
  localparam logic [7:0]  APB_RDATA   = 8'h10;
  localparam int          CMD_READ    = 0;
  localparam int          CMD_WRITE   = 1;
  localparam int          ST_BUSY     = 0;
  localparam int          ST_DONE     = 1;
  localparam int          ST_WFLAG    = 2;
  localparam logic        GIE_RST     = 1'h1;

endpackage

// ---- ebac_if.sv ----
// register access link between the core-side controller and the store
`timescale 1ns/100ps
interface ebac_if;
  logic       acc_req;          // one access this cycle
  logic       acc_we;           // 1 write, 0 read
  logic       bank_pointer;     // data memory bank select
  logic [7:0] acc_addr;         // register offset / indirect pointer
  logic [7:0] acc_wdata;
  logic [7:0] acc_rdata;        // same-cycle read data
  logic       write_done_flag;  // sticky write-done request
  logic       mfi_flag;         // sticky multi-function request
  logic       done_clr;         // clear write-done request
  logic       mfi_clr;          // clear multi-function request

  modport device (
    input  acc_req,
    input  acc_we,
    input  bank_pointer,
    input  acc_addr,
    input  acc_wdata,
    output acc_rdata,
    output write_done_flag,
    output mfi_flag,
    input  done_clr,
    input  mfi_clr
  );

  modport host (
    output acc_req,
    output acc_we,
    output bank_pointer,
    output acc_addr,
    output acc_wdata,
    input  acc_rdata,
    input  write_done_flag,
    input  mfi_flag,
    output done_clr,
    output mfi_clr
  );
endinterface // ebac_if

// ---- ebac_host.sv ----
// core-side controller: apb orders turned into store access sequences
`timescale 1ns/100ps
module ebac_host (
  input  logic        clk,
  input  logic        nrst,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  output logic        global_irq_enable,
  output logic        low_power_ok,      // no cycle in progress
  ebac_if.host        bus
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  typedef enum logic [11:0] {
    EBAC_H_IDLE   = 12'b000000000001,
    EBAC_H_R_EN   = 12'b000000000010,
    EBAC_H_R_ADR  = 12'b000000000100,
    EBAC_H_R_GO   = 12'b000000001000,
    EBAC_H_R_POLL = 12'b000000010000,
    EBAC_H_R_TAKE = 12'b000000100000,
    EBAC_H_W_ADR  = 12'b000001000000,
    EBAC_H_W_DAT  = 12'b000010000000,
    EBAC_H_W_EN   = 12'b000100000000,
    EBAC_H_W_GO   = 12'b001000000000,
    EBAC_H_W_POLL = 12'b010000000000,
    EBAC_H_FIN    = 12'b100000000000
  } ebac_host_state_t;

  ebac_host_state_t state_q;
  logic [5:0]       addr_q;
  logic [7:0]       wdata_q;
  logic [7:0]       rdata_q;
  logic             op_done_q;
  logic             gie_q;
  logic [31:0]      prdata_q;
  logic             apb_wr;
  logic             mapped;
  logic             cmd_wr;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign mapped  = (paddr == ebac_pkg::APB_CMD)    |
                   (paddr == ebac_pkg::APB_ADDR)   |
                   (paddr == ebac_pkg::APB_WDATA)  |
                   (paddr == ebac_pkg::APB_STATUS) |
                   (paddr == ebac_pkg::APB_RDATA);
  assign apb_wr  = psel & penable & pwrite & mapped;
  assign cmd_wr  = apb_wr & (paddr == ebac_pkg::APB_CMD);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_q;

  // read data captured in the setup cycle
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      prdata_q <= 32'h00000000;
    else if (psel && !penable)
    begin
      case (paddr)
        ebac_pkg::APB_ADDR:   prdata_q <= {26'h0, addr_q};
        ebac_pkg::APB_WDATA:  prdata_q <= {24'h0, wdata_q};
        ebac_pkg::APB_RDATA:  prdata_q <= {24'h0, rdata_q};
        ebac_pkg::APB_STATUS: prdata_q <= {29'h0, bus.write_done_flag,
                                           op_done_q,
                                           state_q != EBAC_H_IDLE};
        default:              prdata_q <= 32'h00000000;
      endcase
    end
  end

  // operand registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_q  <= ebac_pkg::ADDR_RST;
      wdata_q <= ebac_pkg::DATA_RST;
    end
    else
    begin
      if (apb_wr && paddr == ebac_pkg::APB_ADDR)
        addr_q <= pwdata[5:0];
      if (apb_wr && paddr == ebac_pkg::APB_WDATA)
        wdata_q <= pwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // access sequencer
  // ----------------------------------------------------------------
  // commands while busy are dropped; read wins over write
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_q <= EBAC_H_IDLE;
    else
    begin
      case (state_q)
        EBAC_H_IDLE:
        begin
          if (cmd_wr && pwdata[ebac_pkg::CMD_READ])
            state_q <= EBAC_H_R_EN;
          else if (cmd_wr && pwdata[ebac_pkg::CMD_WRITE])
            state_q <= EBAC_H_W_ADR;
        end
        EBAC_H_R_EN:   state_q <= EBAC_H_R_ADR;
        EBAC_H_R_ADR:  state_q <= EBAC_H_R_GO;
        EBAC_H_R_GO:   state_q <= EBAC_H_R_POLL;
        EBAC_H_R_POLL:
          if (!bus.acc_rdata[ebac_pkg::CTL_RL])
            state_q <= EBAC_H_R_TAKE;
        EBAC_H_R_TAKE: state_q <= EBAC_H_FIN;
        EBAC_H_W_ADR:  state_q <= EBAC_H_W_DAT;
        EBAC_H_W_DAT:  state_q <= EBAC_H_W_EN;
        EBAC_H_W_EN:   state_q <= EBAC_H_W_GO;
        EBAC_H_W_GO:   state_q <= EBAC_H_W_POLL;
        EBAC_H_W_POLL:
          if (!bus.acc_rdata[ebac_pkg::CTL_WL])
            state_q <= EBAC_H_FIN;
        EBAC_H_FIN:    state_q <= EBAC_H_IDLE;
        default:       state_q <= EBAC_H_IDLE;
      endcase
    end
  end

  // one register access per sequencer state, none when idle
  always_comb
  begin
    bus.acc_req      = 1'b1;
    bus.acc_we       = 1'b1;
    bus.bank_pointer = ebac_pkg::CTL_BANK;
    bus.acc_addr     = ebac_pkg::CTL_OFS;
    bus.acc_wdata    = ebac_pkg::CTL_RST;
    bus.done_clr     = 1'b0;
    bus.mfi_clr      = 1'b0;
    case (state_q)
      EBAC_H_R_EN:   bus.acc_wdata = ebac_pkg::CTL_RD_EN;
      EBAC_H_R_GO:   bus.acc_wdata = ebac_pkg::CTL_RD_GO;
      EBAC_H_W_EN:   bus.acc_wdata = ebac_pkg::CTL_WR_EN;
      EBAC_H_W_GO:   bus.acc_wdata = ebac_pkg::CTL_WR_GO;
      EBAC_H_R_POLL,
      EBAC_H_W_POLL: bus.acc_we    = 1'b0;
      EBAC_H_R_ADR,
      EBAC_H_W_ADR:
      begin
        bus.bank_pointer = ebac_pkg::BANK0;
        bus.acc_addr     = ebac_pkg::ADDR_OFS;
        bus.acc_wdata    = {2'h0, addr_q};
      end
      EBAC_H_W_DAT:
      begin
        bus.bank_pointer = ebac_pkg::BANK0;
        bus.acc_addr     = ebac_pkg::DATA_OFS;
        bus.acc_wdata    = wdata_q;
      end
      EBAC_H_R_TAKE:
      begin
        bus.acc_we       = 1'b0;
        bus.bank_pointer = ebac_pkg::BANK0;
        bus.acc_addr     = ebac_pkg::DATA_OFS;
      end
      EBAC_H_FIN:
      begin
        bus.done_clr = bus.write_done_flag;  // ack write request
        bus.mfi_clr  = bus.mfi_flag;
      end
      default:
      begin
        bus.acc_req      = 1'b0;
        bus.acc_we       = 1'b0;
        bus.bank_pointer = ebac_pkg::BANK0;  // bank 0 when idle
      end
    endcase
  end

  // read result and completion flag
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_q   <= ebac_pkg::DATA_RST;
      op_done_q <= 1'b0;
    end
    else
    begin
      if (state_q == EBAC_H_R_TAKE)
        rdata_q <= bus.acc_rdata;
      if (state_q == EBAC_H_FIN)
        op_done_q <= 1'b1;
      else if (cmd_wr)
        op_done_q <= 1'b0;
    end
  end

  // interrupts masked from before permit until launch is issued
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      gie_q <= ebac_pkg::GIE_RST;
    else if (state_q == EBAC_H_W_DAT)
      gie_q <= 1'b0;
    else if (state_q == EBAC_H_W_GO)
      gie_q <= 1'b1;
  end

  assign global_irq_enable = gie_q;
  assign low_power_ok      = (state_q == EBAC_H_IDLE);

endmodule // ebac_host

// ---- ebac_assertions.sv ----
// concurrent checks on the register link between host and store
`timescale 1ns/100ps
module ebac_assertions (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       bank_pointer,
  input wire logic [7:0] acc_addr,
  input wire logic [7:0] acc_rdata,
  input wire logic       write_done_flag,
  input wire logic       mfi_flag,
  input wire logic       done_clr
);
  // ----------------------------------------------------------------
  // properties on the link
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // control register currently addressed
  wire logic ctl_sel = bank_pointer && (acc_addr == 8'h40);

  property p_ctl_upper; ctl_sel |-> acc_rdata[7:4] == 4'h0; endproperty
  a_ctl_upper: assert property (p_ctl_upper)
    else $error("control upper bits not zero");
  property p_adr_upper; acc_addr == 8'h1e |-> acc_rdata[7:6] == 2'h0;
  endproperty
  a_adr_upper: assert property (p_adr_upper)
    else $error("address upper bits not zero");
  property p_done_pair; $rose(write_done_flag) |-> mfi_flag; endproperty
  a_done_pair: assert property (p_done_pair)
    else $error("write done without multi-function request");
  property p_done_hold; write_done_flag && !done_clr |=> write_done_flag;
  endproperty
  a_done_hold: assert property (p_done_hold)
    else $error("write done dropped without clear");
  property p_done_clr; done_clr |=> !write_done_flag; endproperty
  a_done_clr: assert property (p_done_clr)
    else $error("write done not cleared");
  property p_rst_clr; $rose(nrst) |-> !write_done_flag && !mfi_flag;
  endproperty
  a_rst_clr: assert property (p_rst_clr)
    else $error("request flags set after reset");
  property p_wr_end;
    ctl_sel && $past(ctl_sel) && $fell(acc_rdata[2]) |-> write_done_flag;
  endproperty
  a_wr_end: assert property (p_wr_end)
    else $error("write launch cleared without done flag");
  property p_rd_len; ctl_sel && $past(ctl_sel) && $rose(acc_rdata[0])
    |=> acc_rdata[0] ##1 !acc_rdata[0]; endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read launch not cleared after read cycle");
endmodule // ebac_assertions

// ---- tb_eeprom_byte_access_control.sv ----
// self-checking bench: host and store joined, driven over apb
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h exp %h", $time, a, e); end end
module tb_eeprom_byte_access_control;
  logic        clk, nrst, tclk, psel, penable, pwrite, pready, pslverr;
  logic        gie, lp_ok, busy, err, seen_gie, seen_lp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  ebac_if bus_if ();
  ebac_device #(.WRITE_TICKS(16'h0004)) ebac_device_inst (.clk(clk),
    .nrst(nrst), .wr_timer_clk(tclk), .bus(bus_if), .cycle_busy(busy));
  ebac_host ebac_host_inst (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(gie), .low_power_ok(lp_ok), .bus(bus_if));
  ebac_assertions ebac_assertions_inst (.clk(clk), .nrst(nrst),
    .bank_pointer(bus_if.bank_pointer), .acc_addr(bus_if.acc_addr),
    .acc_rdata(bus_if.acc_rdata), .write_done_flag(bus_if.write_done_flag),
    .mfi_flag(bus_if.mfi_flag), .done_clr(bus_if.done_clr));
  // ----------------------------------------------------------------
  // clocks, timeout, watchers
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // free-running write timer clock, unrelated phase
  initial
  begin
    tclk = 1'b0;
    forever #33 tclk = ~tclk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (gie === 1'b0) seen_gie = 1'b1;
    if (lp_ok === 1'b0) seen_lp = 1'b1;
    if (cyc == 20000)
    begin
      error_cnt++;
      $display("wrong value at %0t: timeout", $time);
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 200; i++)
    begin
      apb(1'b0, ebac_pkg::APB_STATUS, 32'h0);
      if (rd[ebac_pkg::ST_BUSY] === 1'b0) break;
    end
    `CHK(rd[ebac_pkg::ST_BUSY], 1'b0)
  endtask
  task automatic t_reset();
    apb(1'b0, ebac_pkg::APB_STATUS, 32'h0);
    `CHK(rd[2:0], 3'h0)
    `CHK(gie, 1'b1)
    apb(1'b0, 8'h14, 32'h0);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0)
    $display("test reset done");
  endtask
  // write a byte; a read order while busy must be ignored
  task automatic t_write(input logic [7:0] a, d, prev);
    apb(1'b1, ebac_pkg::APB_ADDR, {24'h0, a});
    apb(1'b1, ebac_pkg::APB_WDATA, {24'h0, d});
    seen_gie = 1'b0;
    seen_lp = 1'b0;
    apb(1'b1, ebac_pkg::APB_CMD, 32'h2);
    apb(1'b1, ebac_pkg::APB_CMD, 32'h1);
    @(posedge clk);
    `CHK(busy, 1'b1)
    wait_idle();
    `CHK(busy, 1'b0)
    `CHK(rd[ebac_pkg::ST_WFLAG], 1'b0)
    `CHK(rd[ebac_pkg::ST_DONE], 1'b1)
    `CHK(seen_gie, 1'b1)
    `CHK(seen_lp, 1'b1)
    `CHK(gie, 1'b1)
    apb(1'b0, ebac_pkg::APB_RDATA, 32'h0);
    `CHK(rd[7:0], prev)
    $display("test write done");
  endtask
  task automatic t_read(input logic [7:0] a, d);
    apb(1'b1, ebac_pkg::APB_ADDR, {24'h0, a});
    apb(1'b1, ebac_pkg::APB_CMD, 32'h1);
    wait_idle();
    `CHK(busy, 1'b0)
    apb(1'b0, ebac_pkg::APB_RDATA, 32'h0);
    `CHK(rd[7:0], d)
    apb(1'b0, ebac_pkg::APB_RDATA, 32'h0);
    `CHK(rd[7:0], d)
    $display("test read done");
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_write(8'h3f, 8'ha5, 8'h00);
    t_read(8'h3f, 8'ha5);
    t_write(8'h40, 8'h3c, 8'ha5); // address wraps to 0
    t_read(8'h00, 8'h3c);
    t_read(8'h3f, 8'ha5);
    stop_test();
  end
endmodule // tb_eeprom_byte_access_control
